// ### ctrl_model.sv
module ctrl_model
  import sram_sleep_pkg::*;
(
  input wire logic i_clk,
  output ctrl_t o_ctrl,
  output logic [18:0] o_addr,
  output logic [35:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle is a clean deselect with advance low
  initial begin
    o_ctrl = 9'h110;
    o_addr = 19'h0_0000;
    o_dq = 36'h0_0000_0000;
  end
  task automatic op(input logic w, s, input logic [18:0] a, input logic [35:0] d);
    @(posedge i_clk);
    o_ctrl <= '{1'h0, s, 1'h0, 1'h0, !w, 4'h0};
    o_addr <= a;
    // released data bus shows the inverse of its last value
    o_dq <= w ? d : ~o_dq;
    @(posedge i_clk);
    o_ctrl.cs1_n <= 1'h1;
    o_addr <= ~a;
  endtask
endmodule

// ### sleep_sync.sv
// two-flop synchroniser for the asynchronous sleep request
module sleep_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_r;
  logic sync_r;
  logic meta_nxt;
  logic sync_nxt;

  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule

// ### sram_sleep_ctrl.sv
// Functional notes
// - a new address is captured on every edge where advance and chip select are both low.
// - other synchronous inputs are sampled whenever the device is chip selected.
// - the device stays enabled only while the selects sample as selected on advance-low edges.
// - write-enable low with advance low on an edge makes the cycle a write.
// - write-enable high with advance low on an edge makes the cycle a read.
// - the asynchronous active-high sleep request puts the device to sleep and deselects it.
// - sleep lasts exactly as long as the sleep request is held high; here it starts 3 edges after the rise, ends 5 after the fall.
// - in sleep all inputs but the sleep request are ignored and all outputs float.
// - inputs are ignored no later than two cycles after the sleep request rises.
// - inputs are sampled again within two cycles after the sleep request falls; here they are sampled again only after the fifth edge.
`include "sram_sleep_regs.svh"
module sram_sleep_ctrl
  import sram_sleep_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 36,
  parameter int BW_W = 4,
  parameter int DEPTH = 1024
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_SLEEP_REQUEST,
  input wire logic [ADDR_W-1:0] i_ADDR,
  input wire logic i_CS1_N,
  input wire logic i_CS2,
  input wire logic i_CS2_N,
  input wire logic i_ADDRESS_ADVANCE_N,
  input wire logic i_WE_N,
  input wire logic [BW_W-1:0] i_BYTE_WRITE_N,
  input wire logic [DATA_W-1:0] i_DQ,
  output logic [DATA_W-1:0] o_DQ,
  output logic o_DQ_OE,
  output logic o_SLEEPING,
  output logic o_SELECTED
);
  localparam int IDX_W = $clog2(DEPTH);
  localparam int LANE_W = DATA_W / BW_W;

  logic sleep_req_s;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic sel_r;
  logic sel_nxt;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic rd_pend_r;
  logic rd_pend_nxt;
  logic [BW_W-1:0] bw_r;
  logic [BW_W-1:0] bw_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [DATA_W-1:0] dq_r;
  logic [DATA_W-1:0] dq_nxt;
  logic oe_r;
  logic oe_nxt;
  // fetch-done flag: keeps the enable in step with the output register
  logic rd_vld_r;
  logic rd_vld_nxt;
  logic [DATA_W-1:0] mem [DEPTH];
  pwr_state_t pwr_r;
  pwr_state_t pwr_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic sleeping_r;
  logic sleeping_nxt;
  logic accept;
  logic cs_active;
  logic adv_edge;
  ctrl_t ctl;

  function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
    to_idx = a[IDX_W-1:0];
  endfunction

  sleep_sync u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async(i_SLEEP_REQUEST),
    .o_sync(sleep_req_s)
  );

  // power state: awake -> sleep -> exit (counting) -> awake; enter is never reached
  always_comb begin
    pwr_nxt = pwr_r;
    cnt_nxt = cnt_r;
    sleeping_nxt = sleeping_r;
    case (pwr_r)
      PWR_AWAKE: begin
        if (sleep_req_s) begin
          pwr_nxt = PWR_SLEEP;
          sleeping_nxt = 1'b1;
        end
      end
      PWR_ENTER: begin
        pwr_nxt = PWR_SLEEP;
        sleeping_nxt = 1'b1;
      end
      PWR_SLEEP: begin
        if (!sleep_req_s) begin
          pwr_nxt = PWR_EXIT;
          cnt_nxt = `SLEEP_CNT_ZERO;
        end
      end
      PWR_EXIT: begin
        if (sleep_req_s) begin
          pwr_nxt = PWR_SLEEP;
        end else if (cnt_r == `SLEEP_CNT_ONE) begin
          pwr_nxt = PWR_AWAKE;
          sleeping_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + `SLEEP_CNT_ONE;
        end
      end
      default: begin
        pwr_nxt = PWR_AWAKE;
        cnt_nxt = `SLEEP_CNT_ZERO;
        sleeping_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pwr_r <= PWR_AWAKE;
      cnt_r <= `SLEEP_CNT_ZERO;
      sleeping_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      cnt_r <= cnt_nxt;
      sleeping_r <= sleeping_nxt;
    end
  end

  // synchroniser delay is the two-cycle entry bound; synchronised level gates a cycle before the sleeping flag
  assign accept = !sleeping_r && !sleep_req_s;

  always_comb begin
    ctl.cs1_n = i_CS1_N;
    ctl.cs2 = i_CS2;
    ctl.cs2_n = i_CS2_N;
    ctl.address_advance_n = i_ADDRESS_ADVANCE_N;
    ctl.we_n = i_WE_N;
    ctl.byte_write_n = i_BYTE_WRITE_N;
  end

  assign cs_active = !ctl.cs1_n && ctl.cs2 && !ctl.cs2_n;
  assign adv_edge = accept && !ctl.address_advance_n;

  // cycle qualification and write/read pipeline
  always_comb begin
    addr_nxt = addr_r;
    sel_nxt = sel_r;
    wr_pend_nxt = 1'b0;
    rd_pend_nxt = 1'b0;
    bw_nxt = bw_r;
    if (!accept) begin
      sel_nxt = 1'b0;
    end else if (adv_edge) begin
      sel_nxt = cs_active;
      if (cs_active) begin
        addr_nxt = i_ADDR;
        wr_pend_nxt = !ctl.we_n;
        rd_pend_nxt = ctl.we_n;
        bw_nxt = ctl.byte_write_n;
      end
    end else if (sel_r) begin
      // burst continue: next address, direction from the current write enable
      addr_nxt = addr_r + ADDR_W'(1);
      wr_pend_nxt = !ctl.we_n;
      rd_pend_nxt = ctl.we_n;
      bw_nxt = ctl.byte_write_n;
    end
  end

  // write data lands one edge after the address (late write)
  always_ff @(posedge I_CLK) begin
    if (wr_pend_r && accept) begin
      for (int b = 0; b < BW_W; b++) begin
        if (!bw_r[b]) begin
          mem[to_idx(addr_r)][b*LANE_W +: LANE_W] <= i_DQ[b*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_comb begin
    rd_data_nxt = rd_data_r;
    dq_nxt = dq_r;
    oe_nxt = 1'b0;
    rd_vld_nxt = 1'b0;
    if (rd_pend_r && accept) begin
      rd_data_nxt = mem[to_idx(addr_r)];
      rd_vld_nxt = 1'b1;
    end
    if (accept) begin
      dq_nxt = rd_data_r;
    end
    // enable follows the fetch one edge later, with the data it qualifies
    if (rd_vld_r && accept) begin
      oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      addr_r <= '0;
      sel_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      bw_r <= {BW_W{1'b1}};
      rd_data_r <= '0;
      dq_r <= '0;
      oe_r <= 1'b0;
      rd_vld_r <= 1'b0;
    end else begin
      rd_vld_r <= rd_vld_nxt;
      addr_r <= addr_nxt;
      sel_r <= sel_nxt;
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      bw_r <= bw_nxt;
      rd_data_r <= rd_data_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt && accept;
    end
  end

  assign o_DQ = dq_r;
  assign o_DQ_OE = oe_r;
  assign o_SLEEPING = sleeping_r;
  assign o_SELECTED = sel_r;
endmodule

// ### sram_sleep_ctrl_asserts.sv
module sram_sleep_ctrl_asserts (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_SLEEP_REQUEST,
  input wire logic i_CS1_N,
  input wire logic i_CS2,
  input wire logic i_CS2_N,
  input wire logic i_ADDRESS_ADVANCE_N,
  input wire logic i_WE_N,
  input wire logic o_DQ_OE,
  input wire logic o_SLEEPING,
  input wire logic o_SELECTED
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic go;
  assign go = !i_ADDRESS_ADVANCE_N && !i_CS1_N && i_CS2 && !i_CS2_N
    && !i_SLEEP_REQUEST && !o_SLEEPING;
  chk_read_lat: assert property (go && i_WE_N |-> ##3 o_DQ_OE)
    else $error("read data late");
  chk_write_quiet: assert property (go && !i_WE_N |-> ##3 !o_DQ_OE)
    else $error("write drove data");
  chk_sleep_entry: assert property ($rose(i_SLEEP_REQUEST) |-> ##[1:3] o_SLEEPING)
    else $error("sleep entry late");
  chk_sleep_hold: assert property (i_SLEEP_REQUEST [*4] |-> o_SLEEPING)
    else $error("sleep not held");
  chk_sleep_float: assert property (o_SLEEPING |-> !o_DQ_OE)
    else $error("data driven in sleep");
  chk_sleep_desel: assert property (o_SLEEPING |-> !o_SELECTED)
    else $error("selected in sleep");
  chk_wake_bound: assert property ($fell(i_SLEEP_REQUEST) |-> ##[2:6] !o_SLEEPING)
    else $error("wake late");
  chk_cs_drop: assert property (!i_ADDRESS_ADVANCE_N && i_CS1_N |=> !o_SELECTED)
    else $error("kept selected");
  cover property (go && i_WE_N);
  cover property (go && !i_WE_N);
  cover property ($fell(o_SLEEPING));
endmodule
bind sram_sleep_ctrl sram_sleep_ctrl_asserts u_chk (.I_CLK, .I_RST, .i_SLEEP_REQUEST,
  .i_CS1_N, .i_CS2, .i_CS2_N, .i_ADDRESS_ADVANCE_N, .i_WE_N, .o_DQ_OE,
  .o_SLEEPING, .o_SELECTED);

// ### sram_sleep_pkg.sv
package sram_sleep_pkg;
  typedef enum logic [3:0] {
    PWR_AWAKE = 4'b0001,
    PWR_ENTER = 4'b0010,
    PWR_SLEEP = 4'b0100,
    PWR_EXIT = 4'b1000
  } pwr_state_t;

  typedef struct packed {
    logic cs1_n;
    logic cs2;
    logic cs2_n;
    logic address_advance_n;
    logic we_n;
    logic [3:0] byte_write_n;
  } ctrl_t;
endpackage

// ### sram_sleep_regs.svh
`ifndef SRAM_SLEEP_REGS_SVH
`define SRAM_SLEEP_REGS_SVH
// sleep entry: inputs ignored within this many cycles after the sleep request rises
`define SLEEP_ENTRY_CYC 2'd2
// sleep exit: nominal wake bound in cycles, unused; inputs are sampled again five edges after the request falls
`define SLEEP_EXIT_CYC 2'd2
`define SLEEP_CNT_ZERO 2'd0
`define SLEEP_CNT_ONE 2'd1
`define BW_ALL_OFF 4'h0
`endif

// ### tb_top.sv
module tb_top;
  import sram_sleep_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, zz = 0, oe, slp, sel;
  ctrl_t c;
  logic [18:0] a, ad;
  logic [35:0] d, q, dt, sh [1024];
  int mismatches = 0, checked = 0;
  always #25 clk = ~clk;
  ctrl_model M (.i_clk(clk), .o_ctrl(c), .o_addr(a), .o_dq(d));
  sram_sleep_ctrl DUT (.I_CLK(clk), .I_RST(rst), .i_SLEEP_REQUEST(zz), .i_ADDR(a),
    .i_CS1_N(c.cs1_n), .i_CS2(c.cs2), .i_CS2_N(c.cs2_n),
    .i_ADDRESS_ADVANCE_N(c.address_advance_n), .i_WE_N(c.we_n),
    .i_BYTE_WRITE_N(c.byte_write_n), .i_DQ(d), .o_DQ(q), .o_DQ_OE(oe),
    .o_SLEEPING(slp), .o_SELECTED(sel));
  function logic [35:0] exp_data(input logic [18:0] x);
    return sh[x[9:0]];
  endfunction
  task cmp(input logic [35:0] g, e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [18:0] x, input logic [35:0] v);
    M.op(1'h1, 1'h1, x, v);
    sh[x[9:0]] = v;
  endtask
  task rd(input logic [18:0] x, input logic s);
    logic hit;
    hit = 0;
    M.op(1'h0, s, x, 36'h0_0000_0000);
    @(negedge clk);
    cmp(sel, s);
    repeat (5) begin
      @(negedge clk);
      if (oe === 1'h1 && !hit) begin
        hit = 1;
        cmp(q, exp_data(x));
      end
    end
    cmp(hit, s);
  endtask
  initial begin
    void'($urandom(32'hd66f_289e));
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    wr(19'h0_0000, 36'hf_ffff_ffff);
    wr(19'h0_03ff, 36'h0_0000_0000);
    rd(19'h0_0000, 1'h1);
    rd(19'h0_03ff, 1'h0);
    rd(19'h0_03ff, 1'h1);
    repeat (20) begin
      ad = 19'($urandom_range(1023));
      dt = 36'({$urandom, $urandom});
      wr(ad, dt);
      rd(ad, 1'h1);
    end
    // idle before sleeping, since pending work may be lost
    repeat (3) @(posedge clk);
    zz <= 1;
    repeat (4) @(negedge clk);
    cmp(slp, 1'h1);
    M.op(1'h1, 1'h1, ad, ~dt);
    cmp(slp, 1'h1);
    zz <= 0;
    // no writes while waking: just wait the window out
    repeat (6) @(negedge clk);
    cmp(slp, 1'h0);
    rd(ad, 1'h1);
    wrap_up;
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
endmodule
